// *** sfs_counter.sv ***
// file: one clearable wrapping counter with a variable increment
`timescale 1ns/1ps
module sfs_counter #(
    parameter int CW = 32,
    parameter int IW = 11
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clr,
    input wire logic inc,
    input wire logic [IW-1:0] amount,
    // count
    output logic [CW-1:0] count
);
    import sfs_pkg::*;

    // refused at elaboration, before any clock runs
    if (IW > CW) begin : g_bad_width
        $error("increment wider than counter");
    end

    // ======================================================
    // count
    // wraps at the top
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= SFS_CNT_RST;
        end else if (clr) begin
            // clear wins: management zeroes, event in same cycle dropped
            count <= SFS_CNT_RST;
        end else if (inc) begin
            count <= count + CW'(amount);
        end
    end
endmodule

// *** sfs_monitor.sv ***
// checker: read port timing, refusals and clears of the statistics top
`timescale 1ns/1ps
module sfs_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management
    input wire logic clear_ports,
    input wire logic clear_if,
    input wire logic [2:0] clear_if_index,
    input wire sfs_pkg::sfs_rd_req_t rd_req,
    input wire logic rd_valid,
    input wire logic rd_err,
    input wire logic [31:0] rd_data
);
    import sfs_pkg::*;
    logic prd;
    logic ird;
    assign prd = rd_req.vld && rd_req.sel <= SFS_SEL_FORWARDED;
    assign ird = rd_req.vld && rd_req.sel >= SFS_SEL_IN_OCTETS
        && rd_req.sel <= SFS_SEL_IN_ERROR;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // read port
    a_read_answer: assert property (
        rd_req.vld |=> rd_valid) else $error("read not answered");
    a_idle_quiet: assert property (
        !rd_req.vld |=> !rd_valid && !rd_err && rd_data == '0)
        else $error("read output without request");
    a_port_refused: assert property (
        prd && rd_req.index == 3'h7 |=> rd_err && rd_data == '0)
        else $error("port eight not refused");
    a_port_taken: assert property (
        prd && rd_req.index < 3'h7 |=> !rd_err) else $error("port refused");
    a_slot_no_if: assert property (
        ird && rd_req.index >= 3'h6 |=> rd_err && rd_data == '0)
        else $error("slot interface not refused");
    a_if_taken: assert property (
        ird && rd_req.index < 3'h6 |=> !rd_err) else $error("if refused");
    a_bad_sel: assert property (
        rd_req.vld && rd_req.sel > SFS_SEL_IN_ERROR |=> rd_err && !rd_data)
        else $error("unknown selector not refused");
    // ==========================================
    // clears
    a_port_clear: assert property (
        clear_ports ##1 prd && rd_req.index < 3'h7 |=> rd_data == '0)
        else $error("port counter not cleared");
    a_if_clear: assert property (
        clear_if ##1 ird && rd_req.index == $past(clear_if_index)
        |=> rd_data == '0) else $error("interface counter not cleared");
endmodule

// *** sfs_pkg.sv ***
// package: shared constants and carriers for the switch frame statistics
package sfs_pkg;
    // ======================================================
    // sizing
    localparam int SFS_NPORTS = 7;
    localparam int SFS_NIF = 6;
    localparam int SFS_CW = 32;
    localparam int SFS_PORT_W = 3;
    localparam int SFS_SEL_W = 3;
    localparam int SFS_OCT_W = 11;
    localparam logic [SFS_CW-1:0] SFS_CNT_RST = 32'h0000_0000;

    // ======================================================
    // counter selectors for the read port
    typedef enum logic [3:0] {
        SFS_SEL_RX_FRAMES,
        SFS_SEL_TX_FRAMES,
        SFS_SEL_FILTERED,
        SFS_SEL_FORWARDED,
        SFS_SEL_IN_OCTETS,
        SFS_SEL_IN_UCAST,
        SFS_SEL_IN_NUCAST,
        SFS_SEL_IN_DISCARD,
        SFS_SEL_IN_ERROR
    } sfs_sel_t;

    // per-port frame events, one bit per port, single-cycle pulses
    typedef struct packed {
        logic [SFS_NPORTS-1:0] rx;
        logic [SFS_NPORTS-1:0] tx;
        logic [SFS_NPORTS-1:0] filtered;
        logic [SFS_NPORTS-1:0] forwarded;
    } sfs_port_ev_t;

    // per-interface receive event for one interface
    typedef struct packed {
        logic octets_vld;
        logic [SFS_OCT_W-1:0] octets;
        logic ucast;
        logic nucast;
        logic discard;
        logic error;
    } sfs_if_ev_t;

    // management read request
    typedef struct packed {
        logic vld;
        sfs_sel_t sel;
        logic [SFS_PORT_W-1:0] index;
    } sfs_rd_req_t;
endpackage

// *** sfs_port_model.sv ***
// model: port logic raising frame and receive events
`timescale 1ns/1ps
module sfs_port_model (
    // clock
    input wire logic clk,
    // stimulus word from the bench
    input wire logic en,
    input wire logic [31:0] rnd,
    // events toward the block
    output sfs_pkg::sfs_port_ev_t port_ev,
    output sfs_pkg::sfs_if_ev_t if_ev [sfs_pkg::SFS_NIF]
);
    import sfs_pkg::*;
    logic [31:0] w;
    // taken off the active edge so pulses are settled when sampled
    always @(negedge clk) begin
        w <= rnd;
    end
    always_comb begin
        port_ev = en ? w[27:0] : '0;
        for (int i = 0; i < SFS_NIF; i++) begin
            if_ev[i] = en ? {w[i], w[i+10 +: 11], w[i+4 +: 4]} : '0;
        end
    end
endmodule

// *** sfs_stats.sv ***
// file: top of the switch port frame statistics block
//
// Behaviour
// - seven ports: four segments, two fast, one slot
// - count frames received per port
// - count frames transmitted per port
// - count frames filtered per port
// - count frames forwarded per port
// - clear command zeroes all per-port counters
// - interface receive counters, none for slot seven
// - octet total includes bad frames and framing
// - count unicast received packets per interface
// - count broadcast or multicast received packets
// - count error-free inbound discards
// - count errored inbound drops once each
// - interface clear zeroes selected interface only
`timescale 1ns/1ps
module sfs_stats #(
    parameter int NPORTS = sfs_pkg::SFS_NPORTS,
    parameter int NIF = sfs_pkg::SFS_NIF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // frame events from the port logic
    input wire sfs_pkg::sfs_port_ev_t port_ev,
    input wire sfs_pkg::sfs_if_ev_t if_ev [sfs_pkg::SFS_NIF],
    // management commands, one-cycle pulses
    input wire logic clear_ports,
    input wire logic clear_if,
    input wire logic [sfs_pkg::SFS_SEL_W-1:0] clear_if_index,
    // management read port
    input wire sfs_pkg::sfs_rd_req_t rd_req,
    output logic rd_valid,
    output logic rd_err,
    output logic [sfs_pkg::SFS_CW-1:0] rd_data
);
    import sfs_pkg::*;

    // ======================================================
    // elaboration checks
    // seven ports, six interfaces without the slot
    // refused at elaboration: read decode assumes these sizes
    if (NPORTS != SFS_NPORTS || NIF != SFS_NIF) begin : g_bad_size
        $error("block is built for seven ports and six interfaces");
    end

    logic [SFS_CW-1:0] rx_cnt [NPORTS];
    logic [SFS_CW-1:0] tx_cnt [NPORTS];
    logic [SFS_CW-1:0] flt_cnt [NPORTS];
    logic [SFS_CW-1:0] fwd_cnt [NPORTS];
    logic [SFS_CW-1:0] oct_cnt [NIF];
    logic [SFS_CW-1:0] uc_cnt [NIF];
    logic [SFS_CW-1:0] nuc_cnt [NIF];
    logic [SFS_CW-1:0] dis_cnt [NIF];
    logic [SFS_CW-1:0] err_cnt [NIF];
    logic [NIF-1:0] if_clr;

    // interface clear decode, out-of-range index clears nothing
    function automatic logic [NIF-1:0] if_decode(
        input logic [SFS_SEL_W-1:0] idx
    );
        logic [NIF-1:0] d;
        d = '0;
        for (int k = 0; k < NIF; k++) begin
            if (idx == SFS_SEL_W'(k)) begin
                d[k] = 1'b1;
            end
        end
        return d;
    endfunction

    always_comb begin
        if_clr = clear_if ? if_decode(clear_if_index) : '0;
    end

    // ======================================================
    // per-port counters
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        // received frames, cleared by port clear
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_rx (
            .clk(clk),
            .rst(rst),
            .clr(clear_ports),
            .inc(port_ev.rx[p]),
            .amount(1'b1),
            .count(rx_cnt[p])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_tx (
            .clk(clk),
            .rst(rst),
            .clr(clear_ports),
            .inc(port_ev.tx[p]),
            .amount(1'b1),
            .count(tx_cnt[p])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_flt (
            .clk(clk),
            .rst(rst),
            .clr(clear_ports),
            .inc(port_ev.filtered[p]),
            .amount(1'b1),
            .count(flt_cnt[p])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_fwd (
            .clk(clk),
            .rst(rst),
            .clr(clear_ports),
            .inc(port_ev.forwarded[p]),
            .amount(1'b1),
            .count(fwd_cnt[p])
        );
    end

    // ======================================================
    // per-interface receive counters
    // interfaces 0..5 only; the slot has none
    for (genvar i = 0; i < NIF; i++) begin : g_if
        // every byte, good or bad, framing included
        sfs_counter #(.CW(SFS_CW), .IW(SFS_OCT_W)) u_oct (
            .clk(clk),
            .rst(rst),
            .clr(if_clr[i]),
            .inc(if_ev[i].octets_vld),
            .amount(if_ev[i].octets),
            .count(oct_cnt[i])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_uc (
            .clk(clk),
            .rst(rst),
            .clr(if_clr[i]),
            .inc(if_ev[i].ucast),
            .amount(1'b1),
            .count(uc_cnt[i])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_nuc (
            .clk(clk),
            .rst(rst),
            .clr(if_clr[i]),
            .inc(if_ev[i].nucast),
            .amount(1'b1),
            .count(nuc_cnt[i])
        );
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_dis (
            .clk(clk),
            .rst(rst),
            .clr(if_clr[i]),
            .inc(if_ev[i].discard),
            .amount(1'b1),
            .count(dis_cnt[i])
        );
        // one per errored packet, any error kind
        sfs_counter #(.CW(SFS_CW), .IW(1)) u_err (
            .clk(clk),
            .rst(rst),
            .clr(if_clr[i]),
            .inc(if_ev[i].error),
            .amount(1'b1),
            .count(err_cnt[i])
        );
    end

    // ======================================================
    // read port: registered answer one cycle after request
    logic [SFS_CW-1:0] rd_data_nxt;
    logic rd_err_nxt;
    logic port_ok;
    logic if_ok;

    always_comb begin
        port_ok = int'(rd_req.index) < NPORTS;
        if_ok = int'(rd_req.index) < NIF;
        rd_data_nxt = SFS_CNT_RST;
        rd_err_nxt = 1'b0;
        unique case (rd_req.sel)
            SFS_SEL_RX_FRAMES, SFS_SEL_TX_FRAMES,
            SFS_SEL_FILTERED, SFS_SEL_FORWARDED: begin
                if (!port_ok) begin
                    rd_err_nxt = 1'b1;
                end else if (rd_req.sel == SFS_SEL_RX_FRAMES) begin
                    rd_data_nxt = rx_cnt[rd_req.index];
                end else if (rd_req.sel == SFS_SEL_TX_FRAMES) begin
                    rd_data_nxt = tx_cnt[rd_req.index];
                end else if (rd_req.sel == SFS_SEL_FILTERED) begin
                    rd_data_nxt = flt_cnt[rd_req.index];
                end else begin
                    rd_data_nxt = fwd_cnt[rd_req.index];
                end
            end
            SFS_SEL_IN_OCTETS, SFS_SEL_IN_UCAST, SFS_SEL_IN_NUCAST,
            SFS_SEL_IN_DISCARD, SFS_SEL_IN_ERROR: begin
                // slot seven has no interface counters
                if (!if_ok) begin
                    rd_err_nxt = 1'b1;
                end else if (rd_req.sel == SFS_SEL_IN_OCTETS) begin
                    rd_data_nxt = oct_cnt[rd_req.index];
                end else if (rd_req.sel == SFS_SEL_IN_UCAST) begin
                    rd_data_nxt = uc_cnt[rd_req.index];
                end else if (rd_req.sel == SFS_SEL_IN_NUCAST) begin
                    rd_data_nxt = nuc_cnt[rd_req.index];
                end else if (rd_req.sel == SFS_SEL_IN_DISCARD) begin
                    rd_data_nxt = dis_cnt[rd_req.index];
                end else begin
                    rd_data_nxt = err_cnt[rd_req.index];
                end
            end
            default: begin
                rd_err_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_err <= 1'b0;
            rd_data <= SFS_CNT_RST;
        end else begin
            rd_valid <= rd_req.vld;
            rd_err <= rd_req.vld & rd_err_nxt;
            rd_data <= rd_req.vld ? rd_data_nxt : SFS_CNT_RST;
        end
    end
endmodule

// *** tb.sv ***
// testbench: random traffic, clears and reads against a counter model
`timescale 1ns/1ps
module tb;
    import sfs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic [31:0] rnd = 32'h0;
    logic [31:0] seed = 32'h6705;
    sfs_port_ev_t port_ev;
    sfs_if_ev_t if_ev [SFS_NIF];
    logic clear_ports = 1'b0;
    logic clear_if = 1'b0;
    logic [2:0] clear_if_index = 3'h0;
    sfs_rd_req_t rd_req = '0;
    logic rd_valid;
    logic rd_err;
    logic [31:0] rd_data;
    logic [31:0] pc [4][SFS_NPORTS];
    logic [31:0] ic [5][SFS_NIF];
    logic [33:0] want = 34'h0;
    int err_total = 0;
    int checked = 0;

    always #20 clk = ~clk;

    sfs_port_model pm (.clk(clk), .en(en), .rnd(rnd), .port_ev(port_ev),
        .if_ev(if_ev));
    sfs_stats dut (.clk(clk), .rst(rst), .port_ev(port_ev), .if_ev(if_ev),
        .clear_ports(clear_ports), .clear_if(clear_if),
        .clear_if_index(clear_if_index), .rd_req(rd_req),
        .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

    // ==========================================
    // reference counters; a clear beats a same-cycle event
    always @(posedge clk or posedge rst) begin
        for (int p = 0; p < SFS_NPORTS; p++) begin
            for (int k = 0; k < 4; k++) begin
                if (rst || clear_ports) pc[k][p] = 32'h0;
                else pc[k][p] = pc[k][p] + 32'(port_ev[(3-k)*7+p]);
            end
        end
        for (int i = 0; i < SFS_NIF; i++) begin
            for (int c = 0; c < 5; c++) begin
                if (rst || (clear_if && clear_if_index == i)) ic[c][i] = 0;
                else if (c > 0) ic[c][i] = ic[c][i] + 32'(if_ev[i][4-c]);
                // octet sum wraps at 32 bits
                else if (if_ev[i].octets_vld)
                    ic[0][i] = ic[0][i] + 32'(if_ev[i].octets);
            end
        end
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [33:0] exp_rd(sfs_rd_req_t r);
        if (!r.vld)
            return 34'h0;
        if (r.sel <= SFS_SEL_FORWARDED && r.index < 3'h7)
            return {2'b10, pc[r.sel][r.index]};
        if (r.sel >= SFS_SEL_IN_OCTETS && r.sel <= SFS_SEL_IN_ERROR
            && r.index < 3'h6)
            return {2'b10, ic[r.sel-4][r.index]};
        return 34'h3_0000_0000;
    endfunction
    task automatic check(logic [33:0] seen, logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step(sfs_rd_req_t r, logic cp, logic ci, logic [2:0] cx);
        @(negedge clk);
        check({rd_valid, rd_err, rd_data}, want);
        seed = xs(seed);
        rnd <= seed;
        clear_ports = cp;
        clear_if = ci;
        clear_if_index = cx;
        want = exp_rd(r);
        rd_req = r;
    endtask
    task automatic run(int n);
        repeat (n) begin
            step({seed[12] | seed[13], seed[11:8], seed[2:0]},
                seed[31:26] == 6'h0, seed[30:27] == 4'h0, seed[18:16]);
        end
    endtask
    task automatic sweep();
        for (int s = 0; s < 16; s++) begin
            for (int x = 0; x < 8; x++) begin
                step({1'b1, 4'(s), 3'(x)}, 1'b0, 1'b0, 3'h0);
            end
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        en = 1'b1;
        run(2500);
        en = 1'b0;
        sweep();
        en = 1'b1;
        // clears under traffic, each read straight after
        step('0, 1'b1, 1'b0, 3'h0);
        step({1'b1, SFS_SEL_RX_FRAMES, 3'h6}, 1'b0, 1'b1, 3'h2);
        step({1'b1, SFS_SEL_IN_OCTETS, 3'h2}, 1'b0, 1'b0, 3'h0);
        step('0, 1'b0, 1'b0, 3'h0);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        en = 1'b0;
        sweep();
        en = 1'b1;
        run(500);
        step('0, 1'b0, 1'b0, 3'h0);
        conclude();
    end

    initial begin
        #(40 * 8000);
        err_total++;
        conclude();
    end
endmodule

bind sfs_stats sfs_monitor mon (.clk(clk), .rst(rst),
    .clear_ports(clear_ports), .clear_if(clear_if),
    .clear_if_index(clear_if_index), .rd_req(rd_req),
    .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));
